// File: hdl/daou_pkg.sv
/*
  package for the digital audio output unit: register map, field layout,
  reset values and timing constants.
  assumes an AXI4-Lite master with 32-bit data and one unit clock aclk.
*/
package daou_pkg;
  localparam logic [7:0] ADDR_CTL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_BASE1  = 8'h08;
  localparam logic [7:0] ADDR_BASE2  = 8'h0c;
  localparam logic [7:0] ADDR_SIZE   = 8'h10;
  localparam logic [7:0] ADDR_TSTAMP = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CL = 8'h1c;

  // control fields
  localparam int CTL_RESET   = 31;
  localparam int CTL_ENABLE  = 0;
  localparam int CTL_AWAKE   = 1;
  localparam int CTL_BUFFER_EMPTY_ERROR_ACKNOWLEDGE = 2;
  localparam int CTL_HBE_IEN = 3;
  // status fields
  localparam int ST_HBE      = 0;
  localparam int ST_BUF1_ACT = 1;

  localparam logic [31:0] STATUS_RST = 32'h0000_0002;
  localparam logic [31:0] ZERO32     = 32'h0000_0000;

  localparam int STAGE_BYTES = 64;
  localparam int STAGE_WORDS = STAGE_BYTES / 4;
  localparam logic [4:0] STAGE_WORDS_C = 5'h1_0;

  // fetch latency limit at 32 kHz, in ns, and its cycle count at 5 ns
  localparam int LAT_NS     = 31250;
  localparam int CLK_NS     = 5;
  localparam int LAT_CYCLES = LAT_NS / CLK_NS;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } daou_word_type;

  typedef enum logic [1:0] {
    DAOU_IDLE  = 2'b00,
    DAOU_LOAD  = 2'b01,
    DAOU_SHIFT = 2'b10
  } daou_state_type;
endpackage : daou_pkg

// File: hdl/daou_top.sv
/*
  digital audio output unit core: register slave, staging buffer, holding
  registers, serial shifter, power-down gating, underrun error, interrupt.
  assumes the memory side delivers words on fill_valid when fill_req is high,
  and that reset and power-down inputs are synchronous to aclk.
*/
// Chosen here: the register offsets and the AXI4-Lite slave port.
module daou_top (
  input  wire logic        aclk,            // unit clock, 200 MHz
  input  wire logic        aresetn,         // chip reset, active low
  input  wire logic        core_reset,      // processor-core reset request
  input  wire logic        global_pd,       // chip global power-down
  input  wire logic        block_pd,        // unit's block power-down bit
  input  wire logic [31:0] awaddr,          // axi write address
  input  wire logic        awvalid,         // axi
  output logic             awready,         // axi
  input  wire logic [31:0] wdata,           // axi
  input  wire logic [3:0]  wstrb,           // axi
  input  wire logic        wvalid,          // axi
  output logic             wready,          // axi
  output logic [1:0]       bresp,           // axi
  output logic             bvalid,          // axi
  input  wire logic        bready,          // axi
  input  wire logic [31:0] araddr,          // axi read address
  input  wire logic        arvalid,         // axi
  output logic             arready,         // axi
  output logic [31:0]      rdata,           // axi
  output logic [1:0]       rresp,           // axi
  output logic             rvalid,          // axi
  input  wire logic        rready,          // axi
  output logic             fill_req,        // staging buffer wants a word
  input  wire logic        fill_valid,      // memory word arrives
  input  wire logic [31:0] fill_data,       // memory word
  output logic             serial_out,      // serial audio bit
  output logic             irq,             // unit interrupt, level
  output logic             wake             // wake processor
);
  logic [31:0] ctl_q, status_q, base1_q, base2_q, size_q, tstamp_q, irq_en_q;
  logic        aw_q, w_q, soft_rst_q;
  logic [7:0]  awa_q;
  logic [31:0] wd_q;
  logic [31:0] stage [daou_pkg::STAGE_WORDS];
  logic [3:0]  wr_ptr_q, rd_ptr_q;
  logic [4:0]  count_q;
  daou_pkg::daou_word_type hold_q [2];
  logic [4:0]  bit_q;
  logic        hold_sel_q;
  logic        out_q;

  // unit reset: chip pin or self-clearing software pulse
  wire unit_rst    = !aresetn || soft_rst_q;
  wire stamp_rst   = !aresetn || core_reset;
  wire running     = !block_pd && !(global_pd && !ctl_q[daou_pkg::CTL_AWAKE]);
  wire enabled     = ctl_q[daou_pkg::CTL_ENABLE];
  wire wr_fire     = aw_q && w_q && !bvalid;
  wire [7:0] wa    = awa_q;
  wire ctl_wr      = wr_fire && wa == daou_pkg::ADDR_CTL;
  wire map_wr      = wa <= daou_pkg::ADDR_IRQ_CL && wa[1:0] == 2'b00;
  wire [7:0] ra    = araddr[7:0];
  wire map_rd      = ra <= daou_pkg::ADDR_IRQ_CL && ra[1:0] == 2'b00;
  wire empty       = count_q == 5'h00;
  wire full        = count_q == daou_pkg::STAGE_WORDS_C;
  wire push        = running && fill_valid && !full;
  wire need_word   = !hold_q[hold_sel_q].valid;
  wire pop         = running && enabled && need_word && !empty;
  // underrun: holding word needed but staging buffer dry
  wire underrun    = running && enabled && need_word && empty;
  wire buffer_empty_error_acknowledge     = ctl_wr && wd_q[daou_pkg::CTL_BUFFER_EMPTY_ERROR_ACKNOWLEDGE];
  wire shift_last  = bit_q == 5'h1_f;
  wire [31:0] ctl_wmask = 32'h0000_000b;

  assign awready  = !aw_q && !bvalid;
  assign wready   = !w_q && !bvalid;
  assign arready  = !rvalid;
  assign fill_req = running && !full;
  assign serial_out = out_q;
  assign irq      = status_q[daou_pkg::ST_HBE] && ctl_q[daou_pkg::CTL_HBE_IEN];
  assign wake     = irq && global_pd && ctl_q[daou_pkg::CTL_AWAKE];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q   <= 1'b0;
      w_q    <= 1'b0;
      bvalid <= 1'b0;
      awa_q  <= 8'h00;
      wd_q   <= daou_pkg::ZERO32;
      bresp  <= daou_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_q  <= 1'b1;
        awa_q <= awaddr[7:0];
      end
      if (wvalid && wready) begin
        w_q  <= 1'b1;
        wd_q <= wdata;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= map_wr ? daou_pkg::RESP_OKAY : daou_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_q   <= 1'b0;
        w_q    <= 1'b0;
      end
    end
  end

  // self-clearing reset pulse, one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) soft_rst_q <= 1'b0;
    else soft_rst_q <= ctl_wr && wd_q[daou_pkg::CTL_RESET] && wstrb_ok(wa);
  end

  function automatic logic wstrb_ok(input logic [7:0] a);
    wstrb_ok = a == daou_pkg::ADDR_CTL;
  endfunction : wstrb_ok

  always_ff @(posedge aclk) begin
    if (unit_rst) begin
      ctl_q    <= daou_pkg::ZERO32;
      base1_q  <= daou_pkg::ZERO32;
      base2_q  <= daou_pkg::ZERO32;
      size_q   <= daou_pkg::ZERO32;
      irq_en_q <= daou_pkg::ZERO32;
    end else if (wr_fire) begin
      case (wa)
        daou_pkg::ADDR_CTL:    ctl_q    <= wd_q & ctl_wmask;
        daou_pkg::ADDR_BASE1:  base1_q  <= wd_q;
        daou_pkg::ADDR_BASE2:  base2_q  <= wd_q;
        daou_pkg::ADDR_SIZE:   size_q   <= wd_q;
        daou_pkg::ADDR_IRQ_EN: irq_en_q <= wd_q & daou_pkg::STATUS_RST;
        default: ;
      endcase
    end
  end

  // error flag: set wins over acknowledge and over an ADDR_IRQ_CL write, which also clears it
  always_ff @(posedge aclk) begin
    if (unit_rst) status_q <= daou_pkg::STATUS_RST;
    else begin
      status_q[daou_pkg::ST_HBE] <= underrun || (status_q[daou_pkg::ST_HBE] && !buffer_empty_error_acknowledge);
      if (wr_fire && wa == daou_pkg::ADDR_IRQ_CL && wd_q[daou_pkg::ST_HBE] && !underrun)
        status_q[daou_pkg::ST_HBE] <= 1'b0;
    end
  end

  // timestamp follows the processor cycle counter, so soft reset spares it
  always_ff @(posedge aclk) begin
    if (stamp_rst) tstamp_q <= daou_pkg::ZERO32;
    else tstamp_q <= tstamp_q + 32'h0000_0001;
  end

  // staging buffer: 64 bytes as sixteen words
  always_ff @(posedge aclk) begin
    if (push) stage[wr_ptr_q] <= fill_data;
  end

  always_ff @(posedge aclk) begin
    if (unit_rst) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      count_q  <= 5'h00;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 4'h1;
      if (pop) rd_ptr_q <= rd_ptr_q + 4'h1;
      count_q <= 5'(count_q + {4'h0, push} - {4'h0, pop});
    end
  end

  // shifter freezes in place while powered down, so it resumes exactly
  always_ff @(posedge aclk) begin
    if (unit_rst) begin
      hold_q[0]  <= '0;
      hold_q[1]  <= '0;
      bit_q      <= 5'h00;
      hold_sel_q <= 1'b0;
      out_q      <= 1'b0;
    end else if (running) begin
      if (pop) hold_q[hold_sel_q] <= '{valid: 1'b1, data: stage[rd_ptr_q]};
      if (enabled && hold_q[!hold_sel_q].valid) begin
        out_q <= hold_q[!hold_sel_q].data[bit_q];
        bit_q <= bit_q + 5'h0_1;
        if (shift_last) begin
          hold_q[!hold_sel_q].valid <= 1'b0;
          hold_sel_q <= !hold_sel_q;
        end
      end else if (enabled && !hold_q[!hold_sel_q].valid && hold_q[hold_sel_q].valid)
        hold_sel_q <= !hold_sel_q;
    end
  end

  wire [31:0] rd_mux =
    ra == daou_pkg::ADDR_CTL    ? ctl_q :
    ra == daou_pkg::ADDR_STATUS ? status_q :
    ra == daou_pkg::ADDR_BASE1  ? base1_q :
    ra == daou_pkg::ADDR_BASE2  ? base2_q :
    ra == daou_pkg::ADDR_SIZE   ? size_q :
    ra == daou_pkg::ADDR_TSTAMP ? tstamp_q :
    ra == daou_pkg::ADDR_IRQ_EN ? irq_en_q : daou_pkg::ZERO32;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= daou_pkg::ZERO32;
      rresp  <= daou_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= map_rd ? daou_pkg::RESP_OKAY : daou_pkg::RESP_SLVERR;
    end else if (rvalid && rready) rvalid <= 1'b0;
  end

  property p_soft_reset;
    @(posedge aclk) disable iff (!aresetn) ctl_wr && wd_q[daou_pkg::CTL_RESET] |=> ##1
      (ctl_q == daou_pkg::ZERO32 && status_q == daou_pkg::STATUS_RST && size_q == daou_pkg::ZERO32);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset state wrong");
  property p_ctl_reads_zero;
    @(posedge aclk) disable iff (!aresetn) !ctl_q[daou_pkg::CTL_RESET];
  endproperty
  a_ctl_reads_zero: assert property (p_ctl_reads_zero) else $error("reset bit stuck");
  property p_hbe_set;
    @(posedge aclk) disable iff (!aresetn) underrun && !soft_rst_q |=> status_q[daou_pkg::ST_HBE];
  endproperty
  a_hbe_set: assert property (p_hbe_set) else $error("underrun not flagged");
  property p_hbe_sticky;
    @(posedge aclk) disable iff (!aresetn)
      status_q[daou_pkg::ST_HBE] && !buffer_empty_error_acknowledge && !soft_rst_q && !(wr_fire && wa == daou_pkg::ADDR_IRQ_CL)
      |=> status_q[daou_pkg::ST_HBE];
  endproperty
  a_hbe_sticky: assert property (p_hbe_sticky) else $error("error flag dropped");
  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
      irq == (status_q[daou_pkg::ST_HBE] && ctl_q[daou_pkg::CTL_HBE_IEN]);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt mismatch");
  property p_freeze;
    @(posedge aclk) disable iff (!aresetn) !running && !unit_rst |=> $stable(bit_q) && $stable(out_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("shifter moved in power-down");
  property p_stamp_kept;
    @(posedge aclk) disable iff (!aresetn) soft_rst_q && !core_reset |=> tstamp_q != daou_pkg::ZERO32;
  endproperty
  a_stamp_kept: assert property (p_stamp_kept) else $error("timestamp hit by soft reset");
  property p_no_fill_pd;
    @(posedge aclk) disable iff (!aresetn) block_pd |-> !fill_req;
  endproperty
  a_no_fill_pd: assert property (p_no_fill_pd) else $error("fetch during power-down");

  // core reset must not disturb any unit register except the timestamp
  property p_core_keeps;
    @(posedge aclk) disable iff (!aresetn)
      core_reset && !unit_rst && !wr_fire |=> $stable(ctl_q) && $stable(base1_q) && $stable(size_q);
  endproperty
  a_core_keeps: assert property (p_core_keeps) else $error("core reset hit unit state");

  property p_core_stamp;
    @(posedge aclk) disable iff (!aresetn)
      core_reset |=> tstamp_q == daou_pkg::ZERO32;
  endproperty
  a_core_stamp: assert property (p_core_stamp) else $error("timestamp kept over core reset");

  // counter must track the processor cycle counter one for one
  property p_stamp_counts;
    @(posedge aclk) disable iff (!aresetn)
      !stamp_rst |=> tstamp_q == $past(tstamp_q) + 32'h0000_0001;
  endproperty
  a_stamp_counts: assert property (p_stamp_counts) else $error("timestamp skipped");

  property p_soft_pulse;
    @(posedge aclk) disable iff (!aresetn)
      soft_rst_q |=> !soft_rst_q;
  endproperty
  a_soft_pulse: assert property (p_soft_pulse) else $error("reset pulse too long");

  property p_soft_bases;
    @(posedge aclk) disable iff (!aresetn)
      soft_rst_q |=> base1_q == daou_pkg::ZERO32 && base2_q == daou_pkg::ZERO32;
  endproperty
  a_soft_bases: assert property (p_soft_bases) else $error("buffer base kept");

  property p_soft_status;
    @(posedge aclk) disable iff (!aresetn)
      soft_rst_q |=> status_q == daou_pkg::STATUS_RST;
  endproperty
  a_soft_status: assert property (p_soft_status) else $error("status not reset");

  property p_soft_ctl;
    @(posedge aclk) disable iff (!aresetn)
      soft_rst_q |=> ctl_q == daou_pkg::ZERO32;
  endproperty
  a_soft_ctl: assert property (p_soft_ctl) else $error("control not reset");

  property p_gpd_sleep;
    @(posedge aclk) disable iff (!aresetn)
      global_pd && !ctl_q[daou_pkg::CTL_AWAKE] |-> !fill_req;
  endproperty
  a_gpd_sleep: assert property (p_gpd_sleep) else $error("fetch in global power-down");

  property p_awake_dma;
    @(posedge aclk) disable iff (!aresetn)
      global_pd && ctl_q[daou_pkg::CTL_AWAKE] && !block_pd && !full |-> fill_req;
  endproperty
  a_awake_dma: assert property (p_awake_dma) else $error("stay-awake fetch stopped");

  property p_wake;
    @(posedge aclk) disable iff (!aresetn)
      irq && global_pd && ctl_q[daou_pkg::CTL_AWAKE] |-> wake;
  endproperty
  a_wake: assert property (p_wake) else $error("processor not woken");

  // acknowledge clears only when no new underrun lands in the same cycle
  property p_ack_clears;
    @(posedge aclk) disable iff (!aresetn)
      buffer_empty_error_acknowledge && !underrun |=> !status_q[daou_pkg::ST_HBE];
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("acknowledge ignored");

  property p_stage_bound;
    @(posedge aclk) disable iff (!aresetn)
      count_q <= daou_pkg::STAGE_WORDS_C;
  endproperty
  a_stage_bound: assert property (p_stage_bound) else $error("staging overflow");

  property p_full_stops;
    @(posedge aclk) disable iff (!aresetn)
      full |-> !fill_req;
  endproperty
  a_full_stops: assert property (p_full_stops) else $error("fetch into full buffer");

  property p_freeze_buf;
    @(posedge aclk) disable iff (!aresetn)
      !running && !unit_rst |=> $stable(count_q) && $stable(hold_sel_q);
  endproperty
  a_freeze_buf: assert property (p_freeze_buf) else $error("buffer moved in power-down");

  c_underrun: cover property (@(posedge aclk) disable iff (!aresetn) underrun);
  c_ack:      cover property (@(posedge aclk) disable iff (!aresetn) buffer_empty_error_acknowledge);
  c_awake:    cover property (@(posedge aclk) disable iff (!aresetn) global_pd && running && enabled);
  c_core:     cover property (@(posedge aclk) disable iff (!aresetn) core_reset);
  c_soft:     cover property (@(posedge aclk) disable iff (!aresetn) soft_rst_q);
endmodule : daou_top

// File: tb/daou_feeder.sv
/*
  memory-side model for the audio output unit: offers a counting word
  whenever the staging buffer asks, unless the bench stalls it.
  assumes fill_req is a level and a word is taken when fill_valid is high.
*/
module daou_feeder (
  input  wire logic        aclk,       // unit clock
  input  wire logic        aresetn,    // chip reset, active low
  input  wire logic        stall,      // bench holds back memory
  input  wire logic        fill_req,   // unit wants a word
  output logic             fill_valid, // word offered
  output logic [31:0]      fill_data   // offered word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cnt_q;
  // prompt answer unless stalled; a stall stands in for a slow arbiter
  assign fill_valid = fill_req & ~stall;
  // idle cycles show the inverse so a stale word never looks fresh
  assign fill_data  = fill_valid ? cnt_q : ~cnt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_q <= 32'h0000_0000;
    else if (fill_valid) cnt_q <= cnt_q + 32'h0000_0001;
  end
endmodule : daou_feeder

// File: tb/digital_audio_out_reset_power_underflow_tb.sv
/*
  self-checking bench for the audio output unit: resets, power-down, underrun.
  assumes the unit's AXI4-Lite slave and register map from daou_pkg.
*/
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module digital_audio_out_reset_power_underflow_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, core_reset, global_pd, block_pd, stall;
  logic [31:0] awaddr, wdata, araddr, rdata, fill_data, rd;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, fill_req, fill_valid;
  logic        serial_out, irq, wake;
  logic [1:0]  bresp, rresp;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;

  daou_top dut (.aclk, .aresetn, .core_reset, .global_pd, .block_pd, .awaddr, .awvalid,
    .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .fill_req, .fill_valid,
    .fill_data, .serial_out, .irq, .wake);
  daou_feeder mem (.aclk, .aresetn, .stall, .fill_req, .fill_valid, .fill_data);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awaddr <= {24'h00_0000, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK(bresp, daou_pkg::RESP_OKAY)
    @(posedge aclk);
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [1:0] er = daou_pkg::RESP_OKAY);
    araddr <= {24'h00_0000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    rready <= 1'b0;
    `CHK(rresp, er)
    @(posedge aclk);
  endtask : axr

  task automatic t_reset_vals();
    axr(daou_pkg::ADDR_CTL);    `CHK(rd, daou_pkg::ZERO32)
    axr(daou_pkg::ADDR_STATUS); `CHK(rd, daou_pkg::STATUS_RST)
    axr(daou_pkg::ADDR_BASE1);  `CHK(rd, daou_pkg::ZERO32)
    axr(daou_pkg::ADDR_BASE2);  `CHK(rd, daou_pkg::ZERO32)
    axr(daou_pkg::ADDR_SIZE);   `CHK(rd, daou_pkg::ZERO32)
    axr(8'h20, daou_pkg::RESP_SLVERR); `CHK(rd, daou_pkg::ZERO32)
  endtask : t_reset_vals

  task automatic t_core_soft();
    axw(daou_pkg::ADDR_BASE1, 32'h1234_5678);
    axw(daou_pkg::ADDR_BASE2, 32'h5a5a_0040);
    axw(daou_pkg::ADDR_SIZE, 32'h0000_0040);
    axw(daou_pkg::ADDR_CTL, 32'h0000_000b);
    core_reset <= 1'b1;
    tick(2);
    core_reset <= 1'b0;
    axr(daou_pkg::ADDR_TSTAMP); `CHK(rd, daou_pkg::ZERO32)
    axr(daou_pkg::ADDR_BASE1);  `CHK(rd, 32'h1234_5678)
    axr(daou_pkg::ADDR_CTL);    `CHK(rd, 32'h0000_000b)
    axw(daou_pkg::ADDR_CTL, 32'h8000_0000);
    tick(3);
    axr(daou_pkg::ADDR_BASE1);  `CHK(rd, daou_pkg::ZERO32)
    axr(daou_pkg::ADDR_BASE2);  `CHK(rd, daou_pkg::ZERO32)
    axr(daou_pkg::ADDR_SIZE);   `CHK(rd, daou_pkg::ZERO32)
    axr(daou_pkg::ADDR_CTL);    `CHK(rd, daou_pkg::ZERO32)
    axr(daou_pkg::ADDR_STATUS); `CHK(rd, daou_pkg::STATUS_RST)
    axr(daou_pkg::ADDR_TSTAMP); `CHK(rd > 32'h0000_0008, 1'b1)
    `CHK(serial_out, 1'b0)
  endtask : t_core_soft

  task automatic t_underflow();
    stall <= 1'b1;
    axw(daou_pkg::ADDR_CTL, 32'h0000_0009);
    // the full staging buffer and one holding word drain first
    tick(700);
    axr(daou_pkg::ADDR_STATUS); `CHK(rd[0], 1'b1)
    `CHK(irq, 1'b1)
    axw(daou_pkg::ADDR_CTL, 32'h0000_000b);
    global_pd <= 1'b1;
    tick(2);
    `CHK(wake, 1'b1)
    global_pd <= 1'b0;
    // transmit off first so the refill cannot raise the error again
    axw(daou_pkg::ADDR_CTL, 32'h0000_0008);
    stall <= 1'b0;
    tick(50);
    axr(daou_pkg::ADDR_STATUS); `CHK(rd[0], 1'b1)
    axw(daou_pkg::ADDR_CTL, 32'h0000_000c);
    tick(2);
    axr(daou_pkg::ADDR_STATUS); `CHK(rd[0], 1'b0)
    `CHK(irq, 1'b0)
  endtask : t_underflow

  task automatic t_power();
    stall <= 1'b1;
    axw(daou_pkg::ADDR_CTL, 32'h8000_0000);
    tick(3);
    axw(daou_pkg::ADDR_CTL, 32'h0000_0001);
    tick(2);
    `CHK(fill_req, 1'b1)
    block_pd <= 1'b1;
    tick(2);
    `CHK(fill_req, 1'b0)
    block_pd <= 1'b0;
    global_pd <= 1'b1;
    tick(2);
    `CHK(fill_req, 1'b0)
    axw(daou_pkg::ADDR_CTL, 32'h0000_0003);
    `CHK(fill_req, 1'b1)
    global_pd <= 1'b0;
    axw(daou_pkg::ADDR_CTL, 32'h0000_0000);
    axr(daou_pkg::ADDR_STATUS); `CHK(rd[0], 1'b1)
    axw(daou_pkg::ADDR_IRQ_CL, 32'h0000_0001);
    axr(daou_pkg::ADDR_STATUS); `CHK(rd[0], 1'b0)
  endtask : t_power

  initial begin
    {aresetn, core_reset, global_pd, block_pd, stall} = 5'h00;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 32'h0000_0000;
    wdata = 32'h0000_0000;
    araddr = 32'h0000_0000;
    rd = 32'h0000_0000;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_vals();
    t_core_soft();
    t_underflow();
    t_power();
    wrap_up();
  end
endmodule : digital_audio_out_reset_power_underflow_tb
